//--- logic/sse_exec.sv
// Execute unit for sleep entry, subtracts and nibble swap, with an APB register port.
// Behaviour
// - Sleep clears the watchdog counter and its prescaler to zero.
// - Sleep sets the time-out flag and clears the power-down flag.
// - Sleep then puts the processor into its halted low-power state.
// - Subtract with borrow: register plus inverted accumulator plus carry; updates C, DC, Z.
// - Register subtract: register minus accumulator; updates C, DC, Z.
// - Immediate subtract: immediate minus accumulator into accumulator; updates C, DC, Z.
// - Nibble swap exchanges register nibbles and leaves all flags unchanged.
// - For the register subtracts and swap, direction bit 0 writes the accumulator, 1 writes back the addressed register.
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module sse_exec #(
	parameter int RF_DEPTH = 64,
	parameter int WDOG_TICK = sse_pkg::WDOG_TICK_CYCLES
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_arst_n,
	// APB slave.
	input wire sse_pkg::sse_apb_req_s i_apb,
	output var sse_pkg::sse_apb_rsp_s o_apb,
	// Core state seen by the rest of the processor.
	output logic o_halted,
	output logic [7:0] o_acc
);
	typedef struct packed {
		logic [RF_DEPTH-1:0][7:0] rf;
		logic [7:0] acc;
		logic carry;
		logic half_carry;
		logic zero;
		logic timeout_n;
		logic powerdown_n;
		logic halted;
		logic [7:0] wdog;
		logic [7:0] presc;
		logic [15:0] tick_cnt;
		logic [31:0] prdata;
	} sse_state_s;

	localparam logic [15:0] TICK_LAST = 16'(WDOG_TICK - 1);

	sse_state_s state_r;
	sse_state_s state_nxt;
	sse_pkg::sse_op_e op;
	sse_pkg::sse_alu_out_s alu;
	logic [5:0] raddr;
	logic [7:0] imm;
	logic dir;
	logic setup;
	logic wr_access;
	logic mapped;
	logic in_rf;
	logic [5:0] rf_idx;

	assign setup = i_apb.psel && !i_apb.penable;
	assign wr_access = i_apb.psel && i_apb.penable && i_apb.pwrite;
	// Only whole aligned words of the register file are mapped; byte addresses in between raise an error.
	assign in_rf = (i_apb.paddr[1:0] == 2'h0) && (i_apb.paddr >= sse_pkg::OFS_RF_BASE)
		&& (i_apb.paddr <= sse_pkg::OFS_RF_LAST);
	assign rf_idx = i_apb.paddr[7:2];
	assign mapped = in_rf || (i_apb.paddr == sse_pkg::OFS_CMD) || (i_apb.paddr == sse_pkg::OFS_STATUS)
		|| (i_apb.paddr == sse_pkg::OFS_ACC) || (i_apb.paddr == sse_pkg::OFS_WDOG);

	assign op = sse_pkg::sse_op_e'(i_apb.pwdata[sse_pkg::CMD_OP_LSB +: 4]);
	assign dir = i_apb.pwdata[sse_pkg::CMD_DIR_BIT];
	assign raddr = i_apb.pwdata[sse_pkg::CMD_ADDR_LSB +: 6];
	assign imm = i_apb.pwdata[sse_pkg::CMD_IMM_LSB +: 8];

	sse_alu u_alu (
		.i_op(op),
		.i_reg_operand(state_r.rf[raddr]),
		.i_imm(imm),
		.i_acc(state_r.acc),
		.i_carry(state_r.carry),
		.o_out(alu)
	);

	always_comb begin
		state_nxt = state_r;

		// Free running watchdog; the prescaler divides a slow tick before the counter.
		if (state_r.tick_cnt == TICK_LAST) begin
			state_nxt.tick_cnt = 16'h0000;
			state_nxt.presc = state_r.presc + 8'h01;
			if (state_r.presc == 8'hff) begin
				state_nxt.wdog = state_r.wdog + 8'h01;
			end
		end else begin
			state_nxt.tick_cnt = state_r.tick_cnt + 16'h0001;
		end

		// Read data is captured in the setup phase so it is stable for the access phase.
		if (setup) begin
			state_nxt.prdata = 32'h00000000;
			if (in_rf) begin
				state_nxt.prdata = {24'h000000, state_r.rf[rf_idx]};
			end else if (i_apb.paddr == sse_pkg::OFS_STATUS) begin
				state_nxt.prdata[sse_pkg::ST_CARRY_BIT] = state_r.carry;
				state_nxt.prdata[sse_pkg::ST_HALF_BIT] = state_r.half_carry;
				state_nxt.prdata[sse_pkg::ST_ZERO_BIT] = state_r.zero;
				state_nxt.prdata[sse_pkg::ST_TIMEOUT_BIT] = state_r.timeout_n;
				state_nxt.prdata[sse_pkg::ST_PWRDOWN_BIT] = state_r.powerdown_n;
				state_nxt.prdata[sse_pkg::ST_HALTED_BIT] = state_r.halted;
			end else if (i_apb.paddr == sse_pkg::OFS_ACC) begin
				state_nxt.prdata = {24'h000000, state_r.acc};
			end else if (i_apb.paddr == sse_pkg::OFS_WDOG) begin
				state_nxt.prdata = {16'h0000, state_r.presc, state_r.wdog};
			end
		end

		if (wr_access) begin
			if (in_rf) begin
				state_nxt.rf[rf_idx] = i_apb.pwdata[7:0];
			end else if (i_apb.paddr == sse_pkg::OFS_ACC) begin
				state_nxt.acc = i_apb.pwdata[7:0];
			end else if (i_apb.paddr == sse_pkg::OFS_STATUS) begin
				// Software may preset the arithmetic flags and wake a halted core.
				state_nxt.carry = i_apb.pwdata[sse_pkg::ST_CARRY_BIT];
				state_nxt.half_carry = i_apb.pwdata[sse_pkg::ST_HALF_BIT];
				state_nxt.zero = i_apb.pwdata[sse_pkg::ST_ZERO_BIT];
				if (i_apb.pwdata[sse_pkg::ST_WAKE_BIT]) begin
					state_nxt.halted = 1'h0;
				end
			end else if (i_apb.paddr == sse_pkg::OFS_CMD && !state_r.halted) begin
				// A halted core executes nothing until it is woken.
				unique case (op)
					sse_pkg::OP_SLEEP: begin
						state_nxt.wdog = sse_pkg::WDOG_CLEARED;
						state_nxt.presc = sse_pkg::WDOG_CLEARED;
						state_nxt.tick_cnt = 16'h0000;
						state_nxt.timeout_n = 1'h1;
						state_nxt.powerdown_n = 1'h0;
						state_nxt.halted = 1'h1;
					end
					sse_pkg::OP_SUB_BORROW, sse_pkg::OP_SUB_REG, sse_pkg::OP_SWAP: begin
						if (dir) begin
							state_nxt.rf[raddr] = alu.result;
						end else begin
							state_nxt.acc = alu.result;
						end
						if (alu.flags_we) begin
							state_nxt.carry = alu.carry;
							state_nxt.half_carry = alu.half_carry;
							state_nxt.zero = alu.zero;
						end
					end
					sse_pkg::OP_SUB_IMM: begin
						state_nxt.acc = alu.result;
						state_nxt.carry = alu.carry;
						state_nxt.half_carry = alu.half_carry;
						state_nxt.zero = alu.zero;
					end
					default: begin
					end
				endcase
			end
		end
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			state_r <= '0;
			state_r.acc <= sse_pkg::ACC_RST;
			state_r.timeout_n <= sse_pkg::TIMEOUT_RST;
			state_r.powerdown_n <= sse_pkg::PWRDOWN_RST;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Every access completes in its first access cycle.
	assign o_apb = '{pready: 1'h1, pslverr: i_apb.psel && i_apb.penable && !mapped, prdata: state_r.prdata};
	assign o_halted = state_r.halted;
	assign o_acc = state_r.acc;
endmodule
`default_nettype wire

//--- logic/sse_pkg.sv
// Shared constants and types for the subtract, swap and sleep execute block.
package sse_pkg;

	// Register byte offsets on the APB.
	localparam logic [11:0] OFS_CMD = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_ACC = 12'h008;
	localparam logic [11:0] OFS_WDOG = 12'h00c;
	localparam logic [11:0] OFS_RF_BASE = 12'h100;
	localparam logic [11:0] OFS_RF_LAST = 12'h1fc;

	// Command register fields.
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_DIR_BIT = 4;
	localparam int CMD_ADDR_LSB = 8;
	localparam int CMD_IMM_LSB = 16;

	// Status register fields.
	localparam int ST_CARRY_BIT = 0;
	localparam int ST_HALF_BIT = 1;
	localparam int ST_ZERO_BIT = 2;
	localparam int ST_TIMEOUT_BIT = 3;
	localparam int ST_PWRDOWN_BIT = 4;
	localparam int ST_HALTED_BIT = 5;
	localparam int ST_WAKE_BIT = 8;

	// Values after reset, and the watchdog value loaded by sleep.
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic TIMEOUT_RST = 1'h1;
	localparam logic PWRDOWN_RST = 1'h1;
	localparam logic [7:0] WDOG_CLEARED = 8'h00;

	// Watchdog prescaler input tick, in clock cycles.
	localparam int WDOG_TICK_CYCLES = 16;

	typedef enum logic [3:0] {
		OP_NOP,
		OP_SLEEP,
		OP_SUB_BORROW,
		OP_SUB_REG,
		OP_SUB_IMM,
		OP_SWAP
	} sse_op_e;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} sse_apb_req_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} sse_apb_rsp_s;

	typedef struct packed {
		logic [7:0] result;
		logic carry;
		logic half_carry;
		logic zero;
		logic flags_we;
	} sse_alu_out_s;

endpackage

//--- logic/sse_alu.sv
// Arithmetic for the subtract and nibble swap instructions.
`timescale 1ns/1ns
`default_nettype none
module sse_alu (
	// Operation and operands.
	input wire sse_pkg::sse_op_e i_op,
	input wire logic [7:0] i_reg_operand,
	input wire logic [7:0] i_imm,
	input wire logic [7:0] i_acc,
	input wire logic i_carry,
	// Result and flags.
	output var sse_pkg::sse_alu_out_s o_out
);
	logic [7:0] src;
	logic cin;
	logic [8:0] sum;
	logic [4:0] low_sum;

	always_comb begin
		src = (i_op == sse_pkg::OP_SUB_IMM) ? i_imm : i_reg_operand;
		// Subtraction is done as source plus inverted accumulator plus carry in.
		cin = (i_op == sse_pkg::OP_SUB_BORROW) ? i_carry : 1'h1;
		sum = {1'h0, src} + {1'h0, ~i_acc} + {8'h00, cin};
		low_sum = {1'h0, src[3:0]} + {1'h0, ~i_acc[3:0]} + {4'h0, cin};
		o_out.carry = sum[8];
		o_out.half_carry = low_sum[4];
		o_out.result = sum[7:0];
		o_out.zero = (sum[7:0] == 8'h00);
		o_out.flags_we = 1'h1;
		if (i_op == sse_pkg::OP_SWAP) begin
			o_out.result = {i_reg_operand[3:0], i_reg_operand[7:4]};
			o_out.carry = i_carry;
			o_out.half_carry = 1'h0;
			o_out.zero = 1'h0;
			o_out.flags_we = 1'h0;
		end
	end
endmodule
`default_nettype wire

//--- bench/sse_exec_asserts.sv
// Port checker for the execute unit.
`timescale 1ns/1ns
`default_nettype none
module sse_exec_asserts (
	// Watched ports.
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire sse_pkg::sse_apb_req_s i_apb,
	input wire sse_pkg::sse_apb_rsp_s o_apb,
	input wire logic o_halted,
	input wire logic [7:0] o_acc
);
	wire acs = i_apb.psel && i_apb.penable;
	wire wr = acs && i_apb.pwrite;
	wire [11:0] a = i_apb.paddr;
	wire cmd = wr && a == 12'h000 && !o_halted;
	wire wake = wr && a == 12'h004 && i_apb.pwdata[8];
	wire mapped = a[1:0] == 2'h0 && (a <= 12'h00c || (a >= 12'h100 && a <= 12'h1fc));
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);
	a_ready_high: assert property (o_apb.pready) else $error("pready low");
	a_err_map: assert property (acs |-> o_apb.pslverr == !mapped) else $error("bad pslverr");
	a_err_idle: assert property (!acs |-> !o_apb.pslverr) else $error("pslverr outside access");
	a_sleep_halts: assert property (cmd && i_apb.pwdata[3:0] == 4'h1 |=> o_halted)
		else $error("sleep did not halt");
	a_wake_runs: assert property (wake |=> !o_halted) else $error("wake ignored");
	a_halt_holds: assert property (o_halted && !wake |=> o_halted)
		else $error("halt dropped");
	a_imm_sub: assert property (cmd && i_apb.pwdata[3:0] == 4'h4 |=>
		o_acc == $past(i_apb.pwdata[23:16]) - $past(o_acc)) else $error("bad immediate subtract");
	a_acc_write: assert property (wr && a == 12'h008 |=> o_acc == $past(i_apb.pwdata[7:0]))
		else $error("acc write lost");
	a_acc_steady: assert property (!(wr && (a == 12'h008 || a == 12'h000)) |=> $stable(o_acc))
		else $error("acc changed");
endmodule
bind sse_exec sse_exec_asserts u_sse_exec_asserts (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_apb(i_apb),
	.o_apb(o_apb), .o_halted(o_halted), .o_acc(o_acc));
`default_nettype wire

//--- bench/sse_exec_tb.sv
// Self-checking testbench for the execute unit.
`timescale 1ns/1ns
`default_nettype none
module sse_exec_tb;
	logic i_clk;
	logic i_arst_n;
	sse_pkg::sse_apb_req_s req;
	sse_pkg::sse_apb_rsp_s rsp;
	logic halted;
	logic [7:0] acc;
	logic [31:0] rd;
	logic err;
	int n_fail = 0;
	int checked = 0;
	sse_exec #(.WDOG_TICK(2)) u_sse_exec (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_apb(req), .o_apb(rsp),
		.o_halted(halted), .o_acc(acc));
	task automatic summarize;
		if (n_fail == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// One APB transfer; read data and error are taken at the edge that samples pready.
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge i_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
		@(posedge i_clk);
		req.penable <= 1'b1;
		for (i = 0; i < 8; i++) begin
			@(posedge i_clk);
			if (rsp.pready === 1'b1) break;
		end
		if (i == 8) begin
			n_fail++;
			summarize();
		end
		rd = rsp.prdata;
		err = rsp.pslverr;
		req <= '0;
	endtask
	task automatic t_op(input logic [3:0] op, input logic dir, input logic [5:0] ra, input logic [7:0] r,
		input logic [7:0] a, input logic c, input logic [7:0] imm);
		logic [7:0] src;
		logic ci;
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] res;
		logic [31:0] st;
		logic to_rf;
		src = (op == 4'h4) ? imm : r;
		ci = (op == 4'h2) ? c : 1'b1;
		s = {1'b0, src} + {1'b0, ~a} + {8'h0, ci};
		h = {1'b0, src[3:0]} + {1'b0, ~a[3:0]} + {4'h0, ci};
		res = (op == 4'h5) ? {r[3:0], r[7:4]} : s[7:0];
		st = (op == 4'h5) ? {29'h3, 1'b0, 1'b1, c} : {29'h3, s[7:0] == 8'h0, h[4], s[8]};
		to_rf = dir && op != 4'h4;
		xfer(1'b1, {4'h1, ra, 2'h0}, {24'h0, r});
		xfer(1'b1, 12'h008, {24'h0, a});
		xfer(1'b1, 12'h004, {29'h0, 2'h1, c});
		xfer(1'b1, 12'h000, {8'h0, imm, 2'h0, ra, 3'h0, dir, op});
		xfer(1'b0, to_rf ? {4'h1, ra, 2'h0} : 12'h008, 32'h0);
		chk(rd, {24'h0, res});
		if (to_rf) chk({24'h0, acc}, {24'h0, a});
		xfer(1'b0, 12'h004, 32'h0);
		chk(rd, st);
	endtask
	task automatic t_unmapped;
		xfer(1'b1, 12'h010, 32'hff);
		chk({31'h0, err}, 32'h1);
		xfer(1'b0, 12'h010, 32'h0);
		chk({rd[31:1], err}, 32'h1);
	endtask
	task automatic t_sleep;
		repeat (600) @(posedge i_clk);
		xfer(1'b0, 12'h00c, 32'h0);
		chk({31'h0, rd[7:0] != 8'h0}, 32'h1);
		xfer(1'b1, 12'h000, 32'h1);
		xfer(1'b0, 12'h00c, 32'h0);
		chk({31'h0, rd[15:9] == 7'h0 && rd[7:0] == 8'h0}, 32'h1);
		xfer(1'b0, 12'h004, 32'h0);
		chk(rd & 32'h38, 32'h28);
		xfer(1'b1, 12'h008, 32'h11);
		xfer(1'b1, 12'h000, 32'h00990004);
		// Let the commit edge pass so the registered outputs are settled when looked at.
		@(posedge i_clk);
		chk({24'h0, acc}, 32'h11);
		xfer(1'b1, 12'h004, 32'h100);
		@(posedge i_clk);
		chk({31'h0, halted}, 32'h0);
	endtask
	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end
	initial begin
		req = '0;
		i_arst_n = 1'b0;
		repeat (3) @(posedge i_clk);
		i_arst_n <= 1'b1;
		t_unmapped();
		t_op(4'h2, 1'b0, 6'd63, 8'h50, 8'h30, 1'b0, 8'h0);
		t_op(4'h2, 1'b1, 6'd0, 8'h08, 8'h09, 1'b1, 8'h0);
		t_op(4'h3, 1'b1, 6'd5, 8'h10, 8'h01, 1'b0, 8'h0);
		t_op(4'h3, 1'b0, 6'd7, 8'h3c, 8'h3c, 1'b0, 8'h0);
		t_op(4'h4, 1'b1, 6'd9, 8'h00, 8'h80, 1'b0, 8'h7f);
		t_op(4'h5, 1'b0, 6'd2, 8'ha5, 8'h00, 1'b1, 8'h0);
		t_op(4'h5, 1'b1, 6'd63, 8'h3c, 8'h44, 1'b0, 8'h0);
		t_sleep();
		summarize();
	end
endmodule
`default_nettype wire
